// [keu_unit.sv]
`timescale 1ns/10ps

module keu_unit #(
    parameter int NUM_KEYS = keu_pkg::KEU_NUM_KEYS
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // interrupt pins, idle high
    input  wire logic                extIntPinN,
    input  wire logic [NUM_KEYS-1:0] keypadPinN,
    // software control and core signals
    input  wire keu_pkg::keu_ctrl_t  ctrl,
    input  wire logic                breakState,
    input  wire logic                vectorFetch,
    // status and request
    output      keu_pkg::keu_stat_t  stat
);

    // ****************************************************************
    // state record
    // ****************************************************************
    typedef struct packed {
        keu_pkg::keu_cfg_t   cfg;
        keu_pkg::keu_latch_t extSt;
        keu_pkg::keu_latch_t kbdSt;
        logic                extLowPrev;
        logic                kbdLowPrev;
        logic [1:0]          settleCnt;
        keu_pkg::keu_stat_t  stat;
    } keu_state_t;

    keu_state_t state;
    keu_state_t next_state;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic                extPinSync;
    logic [NUM_KEYS-1:0] kbdPinSync;

    keu_sync #(
        .WIDTH   (1),
        .RST_LVL (keu_pkg::KEU_RST_PIN_LVL)
    ) u_ext_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .asyncIn (extIntPinN),
        .syncOut (extPinSync)
    );

    keu_sync #(
        .WIDTH   (NUM_KEYS),
        .RST_LVL (keu_pkg::KEU_RST_PIN_LVL)
    ) u_kbd_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .asyncIn (keypadPinN),
        .syncOut (kbdPinSync)
    );

    // ****************************************************************
    // latch step, shared by both sources
    // ****************************************************************
    // a set in the same cycle as a clear wins, so no edge is lost
    function automatic keu_pkg::keu_latch_t latch_step(
        input keu_pkg::keu_latch_t st,
        input logic                fall,
        input logic                low,
        input logic                ack,
        input logic                level
    );
        keu_pkg::keu_latch_t nx;
        nx = st;
        case (st)
            keu_pkg::KEU_LATCH_IDLE: begin
                if (fall || (level && low)) begin
                    nx = keu_pkg::KEU_LATCH_SET;
                end
            end
            keu_pkg::KEU_LATCH_SET: begin
                if (ack) begin
                    if (fall) begin
                        nx = keu_pkg::KEU_LATCH_SET;
                    end else if (level && low) begin
                        nx = keu_pkg::KEU_LATCH_ACKED;
                    end else begin
                        nx = keu_pkg::KEU_LATCH_IDLE;
                    end
                end
            end
            keu_pkg::KEU_LATCH_ACKED: begin
                // acknowledged, waiting for the pin to return high
                if (fall) begin
                    nx = keu_pkg::KEU_LATCH_SET;
                end else if (level && low) begin
                    nx = keu_pkg::KEU_LATCH_ACKED;
                end else begin
                    nx = keu_pkg::KEU_LATCH_IDLE;
                end
            end
            default: begin
                nx = keu_pkg::KEU_LATCH_IDLE;
            end
        endcase
        return nx;
    endfunction

    function automatic logic latch_active(
        input keu_pkg::keu_latch_t st
    );
        return st != keu_pkg::KEU_LATCH_IDLE;
    endfunction

    // ****************************************************************
    // detection and next state
    // ****************************************************************
    logic                extLow;
    logic                extFall;
    logic [NUM_KEYS-1:0] kbdLowBits;
    logic                kbdLow;
    logic                kbdFall;
    logic                swAckAllowed;
    logic                extAck;
    logic                kbdAck;
    logic                extActive;
    logic                kbdActive;
    logic                extReq;
    logic                kbdReq;
    logic                pinsValid;

    always_comb begin
        next_state = state;

        // synchroniser outputs hold reset values until filled with real
        // samples; a pin held low through reset must not look like an edge
        pinsValid = state.settleCnt == 2'(keu_pkg::KEU_SYNC_STAGES);
        if (!pinsValid) begin
            next_state.settleCnt = state.settleCnt + 2'h1;
        end

        // only enabled keys take part
        extLow     = pinsValid && !extPinSync;
        extFall    = extLow && !state.extLowPrev;
        kbdLowBits = state.cfg.keypadPinEnables & ~kbdPinSync;
        kbdLow     = pinsValid && (|kbdLowBits);
        // edge only when no enabled key was already low
        kbdFall    = kbdLow && !state.kbdLowPrev;

        // software acks are gated in break unless allowed
        swAckAllowed = !breakState || state.cfg.breakClearAllow;
        extAck = vectorFetch
                 || (ctrl.extAckStrobe && swAckAllowed);
        kbdAck = vectorFetch
                 || (ctrl.keypadAckStrobe && swAckAllowed);

        // treated as already low while settling, so no edge is seen
        next_state.extLowPrev = extLow || !pinsValid;
        next_state.kbdLowPrev = kbdLow || !pinsValid;

        next_state.extSt = latch_step(state.extSt, extFall, extLow, extAck,
                                      state.cfg.extLevelSenseSel);
        next_state.kbdSt = latch_step(state.kbdSt, kbdFall, kbdLow, kbdAck,
                                      state.cfg.keypadLevelSenseSel);

        // configuration copy, cleared by reset
        next_state.cfg.extLevelSenseSel    = ctrl.extLevelSenseSel;
        next_state.cfg.keypadLevelSenseSel = ctrl.keypadLevelSenseSel;
        next_state.cfg.extReqMask          = ctrl.extReqMask;
        next_state.cfg.keypadReqMask       = ctrl.keypadReqMask;
        next_state.cfg.breakClearAllow     = ctrl.breakClearAllow;
        next_state.cfg.keypadPinEnables    = ctrl.keypadPinEnables[NUM_KEYS-1:0];
        next_state.cfg.portDirBits         = ctrl.portDirBits[NUM_KEYS-1:0];

        // request outputs
        extActive = latch_active(next_state.extSt);
        kbdActive = latch_active(next_state.kbdSt);
        extReq    = extActive && !state.cfg.extReqMask;
        kbdReq    = kbdActive && !state.cfg.keypadReqMask;

        next_state.stat.extPendingFlag    = extActive;
        next_state.stat.keypadPendingFlag = kbdActive;
        next_state.stat.intReq            = extReq || kbdReq;
        if (extReq || kbdReq) begin
            next_state.stat.vectorAddr = keu_pkg::KEU_VECTOR_HI;
        end else begin
            next_state.stat.vectorAddr = keu_pkg::KEU_VECTOR_NONE;
        end

        // acknowledge bits are strobes and never read back set
        next_state.stat.extAckRead    = keu_pkg::KEU_RST_ACK_READ;
        next_state.stat.keypadAckRead = keu_pkg::KEU_RST_ACK_READ;

        next_state.stat.extPinLevel = extPinSync;

        // pin steering towards the port logic
        next_state.stat.pullUpEn = state.cfg.keypadPinEnables;
        next_state.stat.pinOutAllowed =
            state.cfg.portDirBits & ~state.cfg.keypadPinEnables;
        next_state.stat.pinReadEn = ~state.cfg.portDirBits;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state.cfg.extLevelSenseSel    <= keu_pkg::KEU_RST_MODE;
            state.cfg.keypadLevelSenseSel <= keu_pkg::KEU_RST_MODE;
            state.cfg.extReqMask          <= keu_pkg::KEU_RST_MASK;
            state.cfg.keypadReqMask       <= keu_pkg::KEU_RST_MASK;
            state.cfg.breakClearAllow     <= keu_pkg::KEU_RST_BRK_ALLOW;
            state.cfg.keypadPinEnables    <= keu_pkg::KEU_RST_KEY_EN;
            state.cfg.portDirBits         <= keu_pkg::KEU_RST_DIR;
            state.extSt                   <= keu_pkg::KEU_LATCH_IDLE;
            state.kbdSt                   <= keu_pkg::KEU_LATCH_IDLE;
            state.extLowPrev              <= 1'b0;
            state.kbdLowPrev              <= 1'b0;
            state.settleCnt               <= 2'h0;
            state.stat.extPendingFlag     <= keu_pkg::KEU_RST_FLAG;
            state.stat.keypadPendingFlag  <= keu_pkg::KEU_RST_FLAG;
            state.stat.extAckRead         <= keu_pkg::KEU_RST_ACK_READ;
            state.stat.keypadAckRead      <= keu_pkg::KEU_RST_ACK_READ;
            state.stat.intReq             <= 1'b0;
            state.stat.vectorAddr         <= keu_pkg::KEU_VECTOR_NONE;
            state.stat.extPinLevel        <= keu_pkg::KEU_RST_PIN_LVL;
            state.stat.pullUpEn           <= keu_pkg::KEU_RST_KEY_EN;
            state.stat.pinOutAllowed      <= keu_pkg::KEU_RST_DIR;
            state.stat.pinReadEn          <= ~keu_pkg::KEU_RST_DIR;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign stat = state.stat;

endmodule

// [keu_pkg.sv]
package keu_pkg;

    // ****************************************************************
    // sizes and fixed values
    // ****************************************************************
    localparam int          KEU_NUM_KEYS      = 6;
    localparam int          KEU_SYNC_STAGES   = 2;
    localparam logic [15:0] KEU_VECTOR_HI     = 16'hFFFA;
    localparam logic [15:0] KEU_VECTOR_LO     = 16'hFFFB;
    localparam logic [15:0] KEU_VECTOR_NONE   = 16'h0000;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic        KEU_RST_MODE      = 1'b0;
    localparam logic        KEU_RST_MASK      = 1'b0;
    localparam logic        KEU_RST_FLAG      = 1'b0;
    localparam logic        KEU_RST_ACK_READ  = 1'b0;
    localparam logic        KEU_RST_BRK_ALLOW = 1'b0;
    localparam logic [5:0]  KEU_RST_KEY_EN    = 6'h00;
    localparam logic [5:0]  KEU_RST_DIR       = 6'h00;
    localparam logic        KEU_RST_PIN_LVL   = 1'b1;

    // ****************************************************************
    // latch states
    // ****************************************************************
    typedef enum logic [1:0] {
        KEU_LATCH_IDLE  = 2'b00,
        KEU_LATCH_SET   = 2'b01,
        KEU_LATCH_ACKED = 2'b10
    } keu_latch_t;

    // ****************************************************************
    // control bits from software; core signals have their own ports
    // ****************************************************************
    typedef struct packed {
        logic       extLevelSenseSel;
        logic       keypadLevelSenseSel;
        logic       extReqMask;
        logic       keypadReqMask;
        logic       extAckStrobe;
        logic       keypadAckStrobe;
        logic       breakClearAllow;
        logic [5:0] keypadPinEnables;
        logic [5:0] portDirBits;
    } keu_ctrl_t;

    // ****************************************************************
    // status and request outputs
    // ****************************************************************
    typedef struct packed {
        logic        extPendingFlag;
        logic        keypadPendingFlag;
        logic        extAckRead;
        logic        keypadAckRead;
        logic        intReq;
        logic [15:0] vectorAddr;
        logic        extPinLevel;
        logic [5:0]  pullUpEn;
        logic [5:0]  pinOutAllowed;
        logic [5:0]  pinReadEn;
    } keu_stat_t;

    // ****************************************************************
    // registered configuration copy
    // ****************************************************************
    typedef struct packed {
        logic       extLevelSenseSel;
        logic       keypadLevelSenseSel;
        logic       extReqMask;
        logic       keypadReqMask;
        logic       breakClearAllow;
        logic [5:0] keypadPinEnables;
        logic [5:0] portDirBits;
    } keu_cfg_t;

endpackage

// [keu_sync.sv]
`timescale 1ns/10ps

module keu_sync #(
    parameter int         WIDTH   = 1,
    parameter logic [0:0] RST_LVL = 1'b1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // pin side
    input  wire logic [WIDTH-1:0] asyncIn,
    // clock side
    output      logic [WIDTH-1:0] syncOut
);

    // ****************************************************************
    // two-stage synchroniser
    // ****************************************************************
    // first stage feeds only the second stage
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1  <= {WIDTH{RST_LVL}};
            syncOut <= {WIDTH{RST_LVL}};
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule

// [keu_unit_assertions.sv]
`timescale 1ns/10ps
module keu_unit_assertions #(
    parameter int NUM_KEYS = 6
) (
    // clock and reset
    input logic                clk,
    input logic                sys_rst,
    // watched ports
    input logic                extIntPinN,
    input logic [NUM_KEYS-1:0] keypadPinN,
    input keu_pkg::keu_ctrl_t  ctrl,
    input logic                breakState,
    input logic                vectorFetch,
    input keu_pkg::keu_stat_t  stat
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [2:0] quietCnt;
    // pins high long enough that no set can still be in the synchroniser
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            quietCnt <= 3'h0;
        else if (!extIntPinN || !(&keypadPinN))
            quietCnt <= 3'h0;
        else if (quietCnt != 3'h7)
            quietCnt <= quietCnt + 3'h1;
    end
    property p_vec;
        stat.vectorAddr == (stat.intReq ? 16'hFFFA : 16'h0000);
    endproperty
    a_vec: assert property (p_vec) else $error("vector mismatch");
    property p_ackrd;
        !stat.extAckRead && !stat.keypadAckRead;
    endproperty
    a_ackrd: assert property (p_ackrd) else $error("ack bit read 1");
    property p_req;
        stat.intReq == (stat.extPendingFlag && !$past(ctrl.extReqMask, 2) ||
            stat.keypadPendingFlag && !$past(ctrl.keypadReqMask, 2));
    endproperty
    a_req: assert property (p_req) else $error("request wrong");
    property p_pull;
        stat.pullUpEn == $past(ctrl.keypadPinEnables, 2) &&
        stat.pinOutAllowed == ($past(ctrl.portDirBits, 2) &
            ~$past(ctrl.keypadPinEnables, 2));
    endproperty
    a_pull: assert property (p_pull) else $error("pin mode wrong");
    property p_set;
        $fell(extIntPinN) ##0
            (!extIntPinN && !ctrl.extAckStrobe && !vectorFetch)[*4]
            |-> stat.extPendingFlag;
    endproperty
    a_set: assert property (p_set) else $error("pin low not latched");
    property p_ack;
        ctrl.extAckStrobe && !breakState && extIntPinN && $past(extIntPinN)
            && $past(extIntPinN, 2) && $past(extIntPinN, 3)
            |=> !stat.extPendingFlag;
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not clear");
    property p_brk;
        breakState && !ctrl.breakClearAllow && !$past(ctrl.breakClearAllow)
            && !vectorFetch && stat.extPendingFlag |=> stat.extPendingFlag;
    endproperty
    a_brk: assert property (p_brk) else $error("latch lost in break");
    property p_fetch;
        vectorFetch && quietCnt == 3'h7
            |=> !stat.extPendingFlag && !stat.keypadPendingFlag;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch left a flag");
endmodule

bind keu_unit keu_unit_assertions #(.NUM_KEYS(NUM_KEYS)) assertInst (
    .clk(clk), .sys_rst(sys_rst), .extIntPinN(extIntPinN),
    .keypadPinN(keypadPinN), .ctrl(ctrl), .breakState(breakState),
    .vectorFetch(vectorFetch), .stat(stat));

// [keu_core_model.sv]
`timescale 1ns/10ps
module keu_core_model (
    // clock and reset
    input  logic        clk,
    input  logic        sys_rst,
    // service on, and cycles the request stands before the fetch
    input  logic        svcOn,
    input  logic [2:0]  svcDly,
    // request side of the block
    input  logic        intReq,
    input  logic [15:0] vecAddr,
    output logic        vectorFetch
);
    logic [2:0] waitCnt;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vectorFetch <= 1'h0;
            waitCnt     <= 3'h0;
        end else begin
            vectorFetch <= 1'h0;
            waitCnt     <= 3'h0;
            // one fetch only: the request drops the edge after it
            if (svcOn && intReq && !vectorFetch && vecAddr == 16'hFFFA) begin
                waitCnt <= waitCnt + 3'h1;
                if (waitCnt == svcDly)
                    vectorFetch <= 1'h1;
            end
        end
    end
endmodule

// [keu_unit_bench.sv]
`timescale 1ns/10ps
module keu_unit_bench;
    // ****************
    // design and partner
    // ****************
    logic               clk;
    logic               sys_rst;
    logic               extIntPinN;
    logic [5:0]         keypadPinN;
    keu_pkg::keu_ctrl_t ctrl;
    logic               breakState;
    logic               vectorFetch;
    logic               svcOn;
    logic [2:0]         svcDly;
    keu_pkg::keu_stat_t stat;
    logic [21:0]        expQ[$];
    logic               chkReq;
    logic [31:0]        seed;
    int                 errorCnt;
    int                 totalChecks;
    int                 cycles;
    keu_unit keu_unit_inst (.clk(clk), .sys_rst(sys_rst),
        .extIntPinN(extIntPinN), .keypadPinN(keypadPinN), .ctrl(ctrl),
        .breakState(breakState), .vectorFetch(vectorFetch), .stat(stat));
    keu_core_model keu_core_model_inst (.clk(clk), .sys_rst(sys_rst),
        .svcOn(svcOn), .svcDly(svcDly), .intReq(stat.intReq),
        .vecAddr(stat.vectorAddr), .vectorFetch(vectorFetch));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // pin modes expected from what the bench itself drives
    task automatic note(input logic e, input logic k, input logic r);
        expQ.push_back({e, k, r, ctrl.keypadPinEnables,
            ctrl.portDirBits & ~ctrl.keypadPinEnables,
            ~ctrl.portDirBits, extIntPinN});
        chkReq = 1'h1;
    endtask
    task automatic ack(input logic k);
        ctrl.extAckStrobe <= !k;
        ctrl.keypadAckStrobe <= k;
        step(1);
        ctrl.extAckStrobe <= 1'h0;
        ctrl.keypadAckStrobe <= 1'h0;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge clk) begin
        logic [21:0] e;
        if (chkReq && expQ.size() > 0) begin
            e = expQ.pop_front();
            chkReq = 1'h0;
            chk("flags", 16'({stat.extPendingFlag, stat.keypadPendingFlag}),
                16'(e[21:20]));
            chk("request", 16'(stat.intReq), 16'(e[19]));
            chk("vector", stat.vectorAddr,
                e[19] ? 16'hFFFA : 16'h0000);
            chk("pullups", 16'(stat.pullUpEn), 16'(e[18:13]));
            chk("outputs", 16'(stat.pinOutAllowed), 16'(e[12:7]));
            chk("readen", 16'(stat.pinReadEn), 16'(e[6:1]));
            chk("pinlevel", 16'(stat.extPinLevel), 16'(e[0]));
            chk("ackread", 16'({stat.extAckRead, stat.keypadAckRead}),
                16'h0000);
        end
    end
    // whole run is about 120 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            reportAndStop();
        end
    end
    initial begin
        sys_rst = 1'h1;
        extIntPinN = 1'h1;
        keypadPinN = 6'h3F;
        ctrl = '0;
        breakState = 1'h0;
        svcOn = 1'h0;
        svcDly = 3'h0;
        chkReq = 1'h0;
        seed = 32'h0000F13C;
        errorCnt = 0;
        totalChecks = 0;
        cycles = 0;
        step(6);
        sys_rst <= 1'h0;
        step(2);
        note(0, 0, 0);
        extIntPinN <= 1'h0;
        step(3);
        note(1, 0, 1);
        ack(0);
        note(0, 0, 0);
        extIntPinN <= 1'h1;
        step(3);
        extIntPinN <= 1'h0;
        step(3);
        note(1, 0, 1);
        extIntPinN <= 1'h1;
        ctrl.extReqMask <= 1'h1;
        step(3);
        note(1, 0, 0);
        ctrl.extReqMask <= 1'h0;
        breakState <= 1'h1;
        step(3);
        ack(0);
        note(1, 0, 1);
        ctrl.breakClearAllow <= 1'h1;
        step(2);
        ack(0);
        breakState <= 1'h0;
        ctrl.breakClearAllow <= 1'h0;
        step(3);
        note(0, 0, 0);
        extIntPinN <= 1'h0;
        step(2);
        extIntPinN <= 1'h1;
        step(4);
        note(1, 0, 1);
        ack(0);
        note(0, 0, 0);
        ctrl.extLevelSenseSel <= 1'h1;
        extIntPinN <= 1'h0;
        step(3);
        ack(0);
        note(1, 0, 1);
        extIntPinN <= 1'h1;
        step(4);
        note(0, 0, 0);
        ctrl.extLevelSenseSel <= 1'h0;
        ctrl.keypadReqMask <= 1'h1;
        step(1);
        ctrl.keypadPinEnables <= 6'h3F;
        step(2);
        ack(1);
        ctrl.keypadReqMask <= 1'h0;
        step(3);
        note(0, 0, 0);
        keypadPinN <= 6'h3E;
        step(3);
        note(0, 1, 1);
        ack(1);
        note(0, 0, 0);
        keypadPinN <= 6'h3C;
        step(4);
        note(0, 0, 0);
        keypadPinN <= 6'h3F;
        step(3);
        keypadPinN <= 6'h3B;
        extIntPinN <= 1'h0;
        step(3);
        note(1, 1, 1);
        keypadPinN <= 6'h3F;
        extIntPinN <= 1'h1;
        svcDly <= 3'(xs());
        step(8);
        svcOn <= 1'h1;
        step(12);
        note(0, 0, 0);
        svcOn <= 1'h0;
        ctrl.keypadLevelSenseSel <= 1'h1;
        keypadPinN <= 6'h1F;
        step(3);
        ack(1);
        note(0, 1, 1);
        keypadPinN <= 6'h3F;
        step(4);
        note(0, 0, 0);
        ctrl.keypadLevelSenseSel <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            ctrl.keypadPinEnables <= 6'(xs());
            ctrl.portDirBits <= 6'(xs());
            step(3);
            note(0, 0, 0);
        end
        ctrl.extLevelSenseSel <= 1'h1;
        extIntPinN <= 1'h0;
        step(3);
        note(1, 0, 1);
        // let the check above sample before reset, and hold the pin low
        // long enough that the pin-low assertion is exercised
        step(2);
        sys_rst <= 1'h1;
        ctrl <= '0;
        step(2);
        sys_rst <= 1'h0;
        step(4);
        note(0, 0, 0);
        extIntPinN <= 1'h1;
        step(2);
        reportAndStop();
    end
endmodule
